// File: verilog/maxs_pkg.sv
// constants, commands and states of the arithmetic, exchange and stack datapath
package maxs_pkg;

    // ****************************************
    // register map of the software port
    // ****************************************
    localparam logic [3:0] REG_WORK   = 4'h0;
    localparam logic [3:0] REG_FLAGS  = 4'h1;
    localparam logic [3:0] REG_STACK  = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;

    // ****************************************
    // flag byte and status byte layout
    // ****************************************
    localparam int FLAG_Z  = 0;
    localparam int FLAG_C  = 1;
    localparam int FLAG_NIBBLE = 2;
    localparam int FLAG_WRAP   = 3;
    localparam int STATUS_BUSY = 0;

    // ****************************************
    // reset values and steps
    // ****************************************
    localparam logic [7:0] WORK_RST  = 8'h00;
    localparam logic [7:0] STACK_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] STACK_STEP = 8'h02;
    localparam logic [7:0] BYTE_ONE   = 8'h01;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;

    // ****************************************
    // commands and sequencer states
    // ****************************************
    typedef enum logic [4:0] {
        OP_XCH_M, OP_PUSH, OP_POP,
        OP_ADD_AI, OP_ADD_AM, OP_ADD_MA,
        OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A, OP_ADDC_M,
        OP_NADD_AM, OP_NADD_MA,
        OP_SUB_AI, OP_SUB_AM, OP_SUB_MA,
        OP_SUBC_AM, OP_SUBC_MA, OP_SUBC_A, OP_SUBC_M,
        OP_INC_M, OP_DEC_M, OP_CLEAR_M
    } maxs_op_t;

    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_EXE, S_PUSH2, S_POP1, S_POP2, S_POP3
    } maxs_state_t;

endpackage

// File: verilog/maxs_datapath.sv
// arithmetic, exchange and stack save/restore datapath of the 8-bit core
// Notes on behaviour
// RQ1 - exchange swaps working register and memory byte, flags untouched
// RQ2 - save writes working register at the stack pointer and flag byte at the next address
// RQ3 - after save the stack pointer advances by two
// RQ4 - restore drops stack pointer by two, then loads working register and all flags
// RQ5 - add immediate into working register, all four flags updated
// RQ6 - add memory byte, result to register or memory, all flags updated
// RQ7 - add memory byte plus carry to selected destination, all flags updated
// RQ8 - single operand add carry to register or memory in place, flags updated
// RQ9 - negate-add into register: memory minus register, flags updated
// RQ10 - negate-add into memory: register minus memory, flags updated
// RQ11 - subtract immediate or memory from register, flags updated
// RQ12 - subtract register from memory byte into memory, flags updated
// RQ13 - register minus memory minus carry into register, flags updated
// RQ14 - memory minus register minus carry into memory, flags updated
// RQ15 - single operand subtract carry in place, flags updated
// RQ16 - increment memory byte, all four flags updated
// RQ17 - decrement memory byte, all four flags updated
// RQ18 - clear writes zero to memory, flags untouched
// RQ19 - on subtraction carry means borrow from bit 7, nibble carry borrow from bit 3
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module maxs_datapath (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             start_i,
    input  maxs_pkg::maxs_op_t    op_i,
    input  wire logic [7:0]       imm_i,
    input  wire logic [7:0]       addr_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic [7:0]            mem_addr_o,
    output logic [7:0]            mem_wdata_o,
    output logic                  mem_we_o,
    output logic                  mem_re_o,
    input  wire logic [7:0]       mem_rdata_i,
    input  wire logic [3:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_write_i,
    input  wire logic             reg_read_i,
    output logic [7:0]            reg_rdata_o,
    output logic [7:0]            working_register_o,
    output logic [7:0]            stack_pointer_o,
    output logic                  zero_flag_o,
    output logic                  carry_flag_o,
    output logic                  nibble_carry_flag_o,
    output logic                  signed_wrap_flag_o
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic needs_read(input maxs_pkg::maxs_op_t op);
        unique case (op)
            maxs_pkg::OP_XCH_M, maxs_pkg::OP_ADD_AM, maxs_pkg::OP_ADD_MA,
            maxs_pkg::OP_ADDC_AM, maxs_pkg::OP_ADDC_MA, maxs_pkg::OP_ADDC_M,
            maxs_pkg::OP_NADD_AM, maxs_pkg::OP_NADD_MA, maxs_pkg::OP_SUB_AM,
            maxs_pkg::OP_SUB_MA, maxs_pkg::OP_SUBC_AM, maxs_pkg::OP_SUBC_MA,
            maxs_pkg::OP_SUBC_M, maxs_pkg::OP_INC_M, maxs_pkg::OP_DEC_M: needs_read = 1'b1;
            default: needs_read = 1'b0;
        endcase
    endfunction

    function automatic logic reg_only(input maxs_pkg::maxs_op_t op);
        reg_only = (op == maxs_pkg::OP_ADD_AI) || (op == maxs_pkg::OP_SUB_AI) ||
                   (op == maxs_pkg::OP_ADDC_A) || (op == maxs_pkg::OP_SUBC_A);
    endfunction

    function automatic logic to_memory(input maxs_pkg::maxs_op_t op);
        unique case (op)
            maxs_pkg::OP_ADD_MA, maxs_pkg::OP_ADDC_MA, maxs_pkg::OP_ADDC_M,
            maxs_pkg::OP_NADD_MA, maxs_pkg::OP_SUB_MA, maxs_pkg::OP_SUBC_MA,
            maxs_pkg::OP_SUBC_M, maxs_pkg::OP_INC_M, maxs_pkg::OP_DEC_M: to_memory = 1'b1;
            default: to_memory = 1'b0;
        endcase
    endfunction

    // returns {wrap, nibble carry, carry, zero, result}; on subtraction carries are borrows
    function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] low;
        logic       wrap;
        full = 9'h000;
        low  = 5'h00;
        wrap = 1'b0;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            wrap = (a[7] != b[7]) && (full[7] != a[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            wrap = (a[7] == b[7]) && (full[7] != a[7]);
        end
        alu = {wrap, low[4], full[8], (full[7:0] == 8'h00), full[7:0]}; // RQ19
    endfunction

    // ****************************************
    // state
    // ****************************************
    maxs_pkg::maxs_state_t state;
    maxs_pkg::maxs_state_t next_state;
    maxs_pkg::maxs_op_t    op_q;
    logic [7:0]            imm_q;
    logic [7:0]            working_register;
    logic [7:0]            stack_pointer;
    logic [3:0]            flags;
    logic                  start_ok;
    logic                  bus_ok;
    logic [7:0]            alu_a;
    logic [7:0]            alu_b;
    logic                  alu_cin;
    logic                  alu_sub;
    logic [11:0]           alu_out;

    assign start_ok = start_i && (state == maxs_pkg::S_IDLE);
    assign bus_ok   = reg_write_i && (state == maxs_pkg::S_IDLE) && !start_i;
    assign alu_out  = alu(alu_a, alu_b, alu_cin, alu_sub);

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            maxs_pkg::S_IDLE: begin
                if (start_i) begin
                    if (op_i == maxs_pkg::OP_PUSH) begin
                        next_state = maxs_pkg::S_PUSH2;
                    end else if (op_i == maxs_pkg::OP_POP) begin
                        next_state = maxs_pkg::S_POP1;
                    end else if (needs_read(op_i)) begin
                        next_state = maxs_pkg::S_RD;
                    end else if (reg_only(op_i)) begin
                        next_state = maxs_pkg::S_EXE;
                    end
                end
            end
            maxs_pkg::S_RD:    next_state = maxs_pkg::S_EXE;
            maxs_pkg::S_EXE:   next_state = maxs_pkg::S_IDLE;
            maxs_pkg::S_PUSH2: next_state = maxs_pkg::S_IDLE;
            maxs_pkg::S_POP1:  next_state = maxs_pkg::S_POP2;
            maxs_pkg::S_POP2:  next_state = maxs_pkg::S_POP3;
            maxs_pkg::S_POP3:  next_state = maxs_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state  <= maxs_pkg::S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            op_q   <= maxs_pkg::OP_XCH_M;
            imm_q  <= maxs_pkg::BYTE_ZERO;
        end else begin
            state  <= next_state;
            busy_o <= (next_state != maxs_pkg::S_IDLE);
            done_o <= ((state != maxs_pkg::S_IDLE) && (next_state == maxs_pkg::S_IDLE)) ||
                      (start_ok && (op_i == maxs_pkg::OP_CLEAR_M));
            if (start_ok) begin
                op_q  <= op_i;
                imm_q <= imm_i;
            end
        end
    end

    // ****************************************
    // operand selection
    // ****************************************
    always_comb begin
        alu_a   = working_register;
        alu_b   = maxs_pkg::BYTE_ZERO;
        alu_cin = 1'b0;
        alu_sub = 1'b0;
        unique case (op_q)
            maxs_pkg::OP_ADD_AI: alu_b = imm_q; // RQ5
            maxs_pkg::OP_ADD_AM, maxs_pkg::OP_ADD_MA: alu_b = mem_rdata_i; // RQ6
            maxs_pkg::OP_ADDC_AM, maxs_pkg::OP_ADDC_MA: begin // RQ7
                alu_b   = mem_rdata_i;
                alu_cin = flags[maxs_pkg::FLAG_C];
            end
            maxs_pkg::OP_ADDC_A: alu_cin = flags[maxs_pkg::FLAG_C]; // RQ8
            maxs_pkg::OP_ADDC_M: begin // RQ8
                alu_a   = mem_rdata_i;
                alu_cin = flags[maxs_pkg::FLAG_C];
            end
            maxs_pkg::OP_NADD_AM, maxs_pkg::OP_SUB_MA: begin // RQ9 RQ12
                alu_a   = mem_rdata_i;
                alu_b   = working_register;
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_NADD_MA, maxs_pkg::OP_SUB_AM: begin // RQ10 RQ11
                alu_b   = mem_rdata_i;
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_SUB_AI: begin // RQ11
                alu_b   = imm_q;
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_SUBC_AM: begin // RQ13
                alu_b   = mem_rdata_i;
                alu_cin = flags[maxs_pkg::FLAG_C];
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_SUBC_MA: begin // RQ14
                alu_a   = mem_rdata_i;
                alu_b   = working_register;
                alu_cin = flags[maxs_pkg::FLAG_C];
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_SUBC_A: begin // RQ15
                alu_cin = flags[maxs_pkg::FLAG_C];
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_SUBC_M: begin // RQ15
                alu_a   = mem_rdata_i;
                alu_cin = flags[maxs_pkg::FLAG_C];
                alu_sub = 1'b1;
            end
            maxs_pkg::OP_INC_M: begin // RQ16
                alu_a = mem_rdata_i;
                alu_b = maxs_pkg::BYTE_ONE;
            end
            maxs_pkg::OP_DEC_M: begin // RQ17
                alu_a   = mem_rdata_i;
                alu_b   = maxs_pkg::BYTE_ONE;
                alu_sub = 1'b1;
            end
            default: alu_a = working_register;
        endcase
    end

    // ****************************************
    // memory port
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_addr_o  <= maxs_pkg::BYTE_ZERO;
            mem_wdata_o <= maxs_pkg::BYTE_ZERO;
            mem_we_o    <= 1'b0;
            mem_re_o    <= 1'b0;
        end else begin
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            if (start_ok) begin
                if (op_i == maxs_pkg::OP_PUSH) begin
                    mem_addr_o  <= stack_pointer; // RQ2
                    mem_wdata_o <= working_register;
                    mem_we_o    <= 1'b1;
                end else if (op_i == maxs_pkg::OP_POP) begin
                    mem_addr_o <= stack_pointer - maxs_pkg::STACK_STEP; // RQ4
                    mem_re_o   <= 1'b1;
                end else if (op_i == maxs_pkg::OP_CLEAR_M) begin
                    mem_addr_o  <= addr_i;
                    mem_wdata_o <= maxs_pkg::BYTE_ZERO; // RQ18
                    mem_we_o    <= 1'b1;
                end else if (needs_read(op_i)) begin
                    mem_addr_o <= addr_i;
                    mem_re_o   <= 1'b1;
                end
            end else if (state == maxs_pkg::S_EXE) begin
                if (op_q == maxs_pkg::OP_XCH_M) begin
                    mem_wdata_o <= working_register; // RQ1
                    mem_we_o    <= 1'b1;
                end else if (to_memory(op_q)) begin
                    mem_wdata_o <= alu_out[7:0]; // RQ6
                    mem_we_o    <= 1'b1;
                end
            end else if (state == maxs_pkg::S_PUSH2) begin
                mem_addr_o  <= mem_addr_o + maxs_pkg::BYTE_ONE; // RQ2
                mem_wdata_o <= {4'h0, flags};
                mem_we_o    <= 1'b1;
            end else if (state == maxs_pkg::S_POP1) begin
                mem_addr_o <= mem_addr_o + maxs_pkg::BYTE_ONE; // RQ4
                mem_re_o   <= 1'b1;
            end
        end
    end

    // ****************************************
    // working register
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            working_register <= maxs_pkg::WORK_RST;
        end else if (state == maxs_pkg::S_EXE) begin
            if (op_q == maxs_pkg::OP_XCH_M) begin
                working_register <= mem_rdata_i; // RQ1
            end else if (!to_memory(op_q)) begin
                working_register <= alu_out[7:0]; // RQ5
            end
        end else if (state == maxs_pkg::S_POP2) begin
            working_register <= mem_rdata_i; // RQ4
        end else if (bus_ok && (reg_addr_i == maxs_pkg::REG_WORK)) begin
            working_register <= reg_wdata_i;
        end
    end

    // ****************************************
    // flags
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags <= maxs_pkg::FLAGS_RST;
        end else if ((state == maxs_pkg::S_EXE) && (op_q != maxs_pkg::OP_XCH_M)) begin
            flags <= alu_out[11:8]; // RQ5
        end else if (state == maxs_pkg::S_POP3) begin
            flags <= mem_rdata_i[3:0]; // RQ4
        end else if (bus_ok && (reg_addr_i == maxs_pkg::REG_FLAGS)) begin
            flags <= reg_wdata_i[3:0];
        end
    end

    // ****************************************
    // stack pointer
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stack_pointer <= maxs_pkg::STACK_RST;
        end else if (start_ok && (op_i == maxs_pkg::OP_POP)) begin
            stack_pointer <= stack_pointer - maxs_pkg::STACK_STEP; // RQ4
        end else if (state == maxs_pkg::S_PUSH2) begin
            stack_pointer <= stack_pointer + maxs_pkg::STACK_STEP; // RQ3
        end else if (bus_ok && (reg_addr_i == maxs_pkg::REG_STACK)) begin
            stack_pointer <= reg_wdata_i;
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= maxs_pkg::BYTE_ZERO;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                maxs_pkg::REG_WORK:   reg_rdata_o <= working_register;
                maxs_pkg::REG_FLAGS:  reg_rdata_o <= {4'h0, flags};
                maxs_pkg::REG_STACK:  reg_rdata_o <= stack_pointer;
                maxs_pkg::REG_STATUS: reg_rdata_o <= {7'h00, busy_o};
                default:              reg_rdata_o <= maxs_pkg::BYTE_ZERO;
            endcase
        end else begin
            reg_rdata_o <= maxs_pkg::BYTE_ZERO;
        end
    end

    assign working_register_o  = working_register;
    assign stack_pointer_o     = stack_pointer;
    assign zero_flag_o         = flags[maxs_pkg::FLAG_Z];
    assign carry_flag_o        = flags[maxs_pkg::FLAG_C];
    assign nibble_carry_flag_o = flags[maxs_pkg::FLAG_NIBBLE];
    assign signed_wrap_flag_o  = flags[maxs_pkg::FLAG_WRAP];

    // ****************************************
    // assertions
    // ****************************************
    sequence s_push_first;
        mem_we_o && (mem_addr_o == $past(stack_pointer)) &&
        (mem_wdata_o == $past(working_register));
    endsequence

    sequence s_push_second;
        mem_we_o && (mem_addr_o == 8'($past(stack_pointer, 2) + 8'h01)) &&
        (mem_wdata_o == {4'h0, $past(flags, 2)});
    endsequence

    sequence s_pop_read;
        mem_re_o && (mem_addr_o == 8'($past(stack_pointer) - 8'h02)) &&
        (stack_pointer == 8'($past(stack_pointer) - 8'h02));
    endsequence

    property p_xch;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == maxs_pkg::S_EXE) && (op_q == maxs_pkg::OP_XCH_M) |=>
            mem_we_o && (mem_wdata_o == $past(working_register)) &&
            (working_register == $past(mem_rdata_i)) && $stable(flags);
    endproperty
    a_xch: assert property (p_xch) else $error("exchange result wrong"); // RQ1

    property p_push;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start_ok && (op_i == maxs_pkg::OP_PUSH) |=> s_push_first ##1 s_push_second;
    endproperty
    a_push: assert property (p_push) else $error("save writes wrong"); // RQ2

    property p_push_sp;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start_ok && (op_i == maxs_pkg::OP_PUSH) |->
            ##2 (stack_pointer == 8'($past(stack_pointer, 2) + 8'h02)) && !busy_o;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("stack pointer not advanced"); // RQ3

    property p_pop;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start_ok && (op_i == maxs_pkg::OP_POP) |=> s_pop_read ##1 mem_re_o
            ##2 (working_register == $past(mem_rdata_i, 2)) &&
                (flags == $past(mem_rdata_i[3:0])) && done_o;
    endproperty
    a_pop: assert property (p_pop) else $error("restore sequence wrong"); // RQ4

    property p_add_imm;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start_ok && (op_i == maxs_pkg::OP_ADD_AI) |->
            ##2 working_register == 8'($past(working_register, 2) + $past(imm_i, 2));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate wrong"); // RQ5

    property p_inc;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == maxs_pkg::S_EXE) && (op_q == maxs_pkg::OP_INC_M) |=>
            mem_we_o && (mem_wdata_o == 8'($past(mem_rdata_i) + 8'h01)) &&
            (zero_flag_o == (mem_wdata_o == 8'h00));
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong"); // RQ16

    property p_dec;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == maxs_pkg::S_EXE) && (op_q == maxs_pkg::OP_DEC_M) |=>
            mem_we_o && (mem_wdata_o == 8'($past(mem_rdata_i) - 8'h01)) &&
            (carry_flag_o == ($past(mem_rdata_i) == 8'h00));
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong"); // RQ17

    property p_clear;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        start_ok && (op_i == maxs_pkg::OP_CLEAR_M) |=>
            mem_we_o && (mem_wdata_o == 8'h00) && $stable(flags) && done_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong"); // RQ18

    property p_sub_borrow;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (state == maxs_pkg::S_EXE) && (op_q == maxs_pkg::OP_SUB_AM) |=>
            (carry_flag_o == ($past(working_register) < $past(mem_rdata_i))) &&
            (nibble_carry_flag_o == ($past(working_register[3:0]) < $past(mem_rdata_i[3:0])));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flags wrong"); // RQ19

endmodule

// File: verification/maxs_mem_model.sv
// data memory and stack ram seen by the datapath
`timescale 1ns/1ps
module maxs_mem_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] mem_addr_i,
    input  wire logic [7:0] mem_wdata_i,
    input  wire logic       mem_we_i,
    input  wire logic       mem_re_i,
    output logic [7:0]      mem_rdata_o
);
    logic [7:0] mem [256];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        mem_rdata_o = 8'h00;
    end
    // read data only in the cycle after the strobe, else scrambled
    always @(posedge ref_clk_i) begin
        if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
        mem_rdata_o <= mem_re_i ? mem[mem_addr_i] : ~mem_rdata_o;
    end
endmodule

// File: verification/mcu_arith_exchange_stack_ops_bench.sv
// self-checking bench of the arithmetic, exchange and stack datapath
`timescale 1ns/1ps
module mcu_arith_exchange_stack_ops_bench;
    typedef struct {
        maxs_pkg::maxs_op_t op;
        logic [7:0] a, m;
        logic [3:0] f;
        logic [7:0] res;
        logic [3:0] fl;
        logic       dm;
    } maxs_row_t;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0;
    logic reg_write_i = 1'b0, reg_read_i = 1'b0;
    maxs_pkg::maxs_op_t op_i = maxs_pkg::OP_CLEAR_M;
    logic [7:0] imm_i = 8'h00, addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] mem_addr_o, mem_wdata_o, mem_rdata_i, reg_rdata_o, wd_s;
    logic [7:0] working_register_o, stack_pointer_o;
    logic busy_o, done_o, mem_we_o, mem_re_o, we_s;
    logic zero_flag_o, carry_flag_o, nibble_carry_flag_o, signed_wrap_flag_o;
    wire [7:0] flags = {4'h0, signed_wrap_flag_o, nibble_carry_flag_o, carry_flag_o, zero_flag_o};
    int n_errors = 0;
    int check_count = 0;
    maxs_row_t rows [19] = '{
        '{maxs_pkg::OP_ADD_AI,8'h78,8'h08,4'h0,8'h80,4'hc,1'b0},
        '{maxs_pkg::OP_ADD_AM,8'hff,8'h01,4'h0,8'h00,4'h7,1'b0},
        '{maxs_pkg::OP_ADD_MA,8'h12,8'h34,4'h0,8'h46,4'h0,1'b1},
        '{maxs_pkg::OP_ADDC_AM,8'h0f,8'h00,4'h2,8'h10,4'h4,1'b0},
        '{maxs_pkg::OP_ADDC_MA,8'h80,8'h80,4'h2,8'h01,4'ha,1'b1},
        '{maxs_pkg::OP_ADDC_A,8'hff,8'h00,4'h2,8'h00,4'h7,1'b0},
        '{maxs_pkg::OP_ADDC_M,8'h00,8'h7f,4'h2,8'h80,4'hc,1'b1},
        '{maxs_pkg::OP_NADD_AM,8'h01,8'h00,4'h0,8'hff,4'h6,1'b0},
        '{maxs_pkg::OP_NADD_MA,8'h80,8'h01,4'h0,8'h7f,4'hc,1'b1},
        '{maxs_pkg::OP_SUB_AI,8'h05,8'h05,4'h0,8'h00,4'h1,1'b0},
        '{maxs_pkg::OP_SUB_AM,8'h10,8'h01,4'h0,8'h0f,4'h4,1'b0},
        '{maxs_pkg::OP_SUB_MA,8'h80,8'h00,4'h0,8'h80,4'ha,1'b1},
        '{maxs_pkg::OP_SUBC_AM,8'h10,8'h0f,4'h2,8'h00,4'h5,1'b0},
        '{maxs_pkg::OP_SUBC_MA,8'h00,8'h00,4'h2,8'hff,4'h6,1'b1},
        '{maxs_pkg::OP_SUBC_A,8'h80,8'h00,4'h2,8'h7f,4'hc,1'b0},
        '{maxs_pkg::OP_SUBC_M,8'h00,8'h10,4'h2,8'h0f,4'h4,1'b1},
        '{maxs_pkg::OP_INC_M,8'h00,8'hff,4'h0,8'h00,4'h7,1'b1},
        '{maxs_pkg::OP_DEC_M,8'h00,8'h00,4'h0,8'hff,4'h6,1'b1},
        '{maxs_pkg::OP_CLEAR_M,8'h00,8'h55,4'hf,8'h00,4'hf,1'b1}
    };
    always #20 ref_clk_i = ~ref_clk_i;
    maxs_datapath DUT (.ref_clk_i, .reset_n_i, .start_i, .op_i, .imm_i, .addr_i, .busy_o,
        .done_o, .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .reg_addr_i,
        .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .working_register_o,
        .stack_pointer_o, .zero_flag_o, .carry_flag_o, .nibble_carry_flag_o,
        .signed_wrap_flag_o);
    maxs_mem_model MEM (.ref_clk_i, .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_rdata_o(mem_rdata_i));
    // ********
    // tasks
    // ********
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1 chk8(reg_rdata_o, e, "reg read");
        @(posedge ref_clk_i);
    endtask
    task automatic cmd(input maxs_pkg::maxs_op_t op, input logic [7:0] v,
                       input logic [7:0] ad);
        int k;
        op_i <= op;
        imm_i <= v;
        addr_i <= ad;
        start_i <= 1'b1;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        for (k = 0; k < 8; k++) begin
            #1;
            if (done_o === 1'b1) break;
            @(posedge ref_clk_i);
        end
        if (k == 8) begin
            n_errors++;
            print_verdict();
        end
        we_s = mem_we_o;
        wd_s = mem_wdata_o;
        @(posedge ref_clk_i);
    endtask
    // ********
    // sequence
    // ********
    initial begin
        repeat (20) @(posedge ref_clk_i);
        chk8(working_register_o | stack_pointer_o | flags, 8'h00, "reset");
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd(4'h9, 8'h00);
        reg_wr(maxs_pkg::REG_STATUS, 8'hff);
        reg_rd(maxs_pkg::REG_STATUS, 8'h00);
        reg_wr(maxs_pkg::REG_FLAGS, 8'hff);
        reg_rd(maxs_pkg::REG_FLAGS, 8'h0f);
        reg_wr(maxs_pkg::REG_STACK, 8'h10);
        reg_rd(maxs_pkg::REG_STACK, 8'h10);
        foreach (rows[i]) begin
            reg_wr(maxs_pkg::REG_WORK, rows[i].a);
            reg_wr(maxs_pkg::REG_FLAGS, {4'h0, rows[i].f});
            MEM.mem[8'h40 + i] = rows[i].m;
            cmd(rows[i].op, rows[i].m, 8'h40 + 8'(i));
            chk8(flags, {4'h0, rows[i].fl}, "flags");
            chk8(rows[i].dm ? wd_s : working_register_o, rows[i].res, "result");
            chk8({7'h0, we_s}, {7'h0, rows[i].dm}, "write strobe");
            if (rows[i].dm) chk8(mem_addr_o, 8'h40 + 8'(i), "address");
        end
        start_i <= 1'b1;
        op_i <= maxs_pkg::OP_INC_M;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        reg_rd(maxs_pkg::REG_STATUS, 8'h01);
        reg_wr(maxs_pkg::REG_WORK, 8'h3c);
        reg_wr(maxs_pkg::REG_FLAGS, 8'h0a);
        MEM.mem[8'h20] = 8'hc3;
        cmd(maxs_pkg::OP_XCH_M, 8'h00, 8'h20);
        chk8(wd_s, 8'h3c, "xch mem");
        chk8(working_register_o, 8'hc3, "xch work");
        chk8(flags, 8'h0a, "xch flags");
        reg_wr(maxs_pkg::REG_WORK, 8'h5a);
        reg_wr(maxs_pkg::REG_FLAGS, 8'h05);
        cmd(maxs_pkg::OP_PUSH, 8'h00, 8'h00);
        chk8(stack_pointer_o, 8'h12, "stack after save");
        reg_wr(maxs_pkg::REG_WORK, 8'h00);
        chk8(MEM.mem[8'h10], 8'h5a, "saved work");
        chk8(MEM.mem[8'h11], 8'h05, "saved flags");
        reg_wr(maxs_pkg::REG_FLAGS, 8'h00);
        cmd(maxs_pkg::OP_POP, 8'h00, 8'h00);
        chk8(stack_pointer_o, 8'h10, "stack after restore");
        chk8(working_register_o, 8'h5a, "restored work");
        chk8(flags, 8'h05, "restored flags");
        reg_rd(maxs_pkg::REG_WORK, 8'h5a);
        print_verdict();
    end
endmodule
